// ==== pkg/spa_pkg.sv ====
// Shared constants and types for the SPI register access link
package spa_pkg;
    // ==========================================================
    // Field widths and positions
    localparam int SPA_DATA_W = 8;
    localparam int SPA_ADDR_W = 7;
    localparam int SPA_WR_BIT = 7;
    localparam int SPA_BIT_CNT_W = 3;
    localparam logic [SPA_BIT_CNT_W-1:0] SPA_BIT_FIRST = 3'h0;
    localparam logic [SPA_BIT_CNT_W-1:0] SPA_BIT_LAST = 3'h7;
    // ==========================================================
    // Address map
    localparam logic [SPA_ADDR_W-1:0] SPA_FIFO_ADDR = 7'h00;
    localparam logic [SPA_ADDR_W-1:0] SPA_ADDR_STEP = 7'h01;
    localparam logic [SPA_DATA_W-1:0] SPA_BYTE_ZERO = 8'h00;
    // ==========================================================
    // Host timing
    localparam int SPA_HALF_DIV = 4;
    localparam int SPA_DIV_W = 8;
    localparam int SPA_LEN_W = 8;
    // ==========================================================
    // Types
    typedef enum logic {
        SPA_ST_ADDR = 1'b0,
        SPA_ST_DATA = 1'b1
    } spa_frame_t;
    typedef enum logic [2:0] {
        SPA_H_IDLE = 3'b000,
        SPA_H_LEAD = 3'b001,
        SPA_H_LOW = 3'b010,
        SPA_H_HIGH = 3'b011,
        SPA_H_TAIL = 3'b100
    } spa_host_t;
endpackage

// ==== pkg/spa_link_if.sv ====
// Serial link between host and device
`timescale 1ns/10ps
`default_nettype none
interface spa_link_if;
    logic sclk;
    logic chip_select_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    modport dev (
        input sclk,
        input chip_select_n,
        input mosi,
        output miso,
        output miso_oe
    );
    modport host (
        output sclk,
        output chip_select_n,
        output mosi,
        input miso,
        input miso_oe
    );
endinterface
`default_nettype wire

// ==== rtl/spa_host.sv ====
// Host end: SPI master that runs framed register accesses
`timescale 1ns/10ps
`default_nettype none
module spa_host #(
    parameter int HALF_DIV = spa_pkg::SPA_HALF_DIV
) (
    input wire logic mclk,
    input wire logic rst,
    spa_link_if.host link,
    input wire logic req,
    input wire logic req_write,
    input wire logic [spa_pkg::SPA_ADDR_W-1:0] req_addr,
    input wire logic [spa_pkg::SPA_LEN_W-1:0] req_len,
    input wire logic [spa_pkg::SPA_DATA_W-1:0] wdata,
    output logic busy,
    output logic byte_done,
    output logic [spa_pkg::SPA_DATA_W-1:0] rdata
);
    import spa_pkg::*;

    localparam logic [SPA_DIV_W-1:0] DIV_LAST = SPA_DIV_W'(HALF_DIV - 1);

    spa_host_t st_r, st_nxt;
    logic [SPA_DIV_W-1:0] div_r, div_nxt;
    logic [SPA_BIT_CNT_W-1:0] bit_r, bit_nxt;
    logic [SPA_LEN_W-1:0] left_r, left_nxt;
    logic [SPA_DATA_W-1:0] tx_r, tx_nxt;
    logic [SPA_DATA_W-1:0] rx_r, rx_nxt;
    logic is_data_r, is_data_nxt;
    logic sclk_r, sclk_nxt;
    logic cs_n_r, cs_n_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic [SPA_DATA_W-1:0] rdata_r, rdata_nxt;
    logic miso_s1_r, miso_s2_r;
    logic div_end;

    // ==========================================================
    // Frame sequencer
    assign div_end = (div_r == DIV_LAST);

    always_comb begin
        st_nxt = st_r;
        div_nxt = div_end ? '0 : div_r + SPA_DIV_W'(1);
        bit_nxt = bit_r;
        left_nxt = left_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        is_data_nxt = is_data_r;
        sclk_nxt = 1'b0;
        cs_n_nxt = cs_n_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        rdata_nxt = rdata_r;
        case (st_r)
            SPA_H_IDLE: begin
                div_nxt = '0;
                if (req) begin
                    tx_nxt = {req_write, req_addr};
                    left_nxt = req_len;
                    is_data_nxt = 1'b0;
                    bit_nxt = SPA_BIT_FIRST;
                    cs_n_nxt = 1'b0;
                    busy_nxt = 1'b1;
                    st_nxt = SPA_H_LEAD;
                end
            end
            SPA_H_LEAD: begin
                if (div_end) begin
                    st_nxt = SPA_H_HIGH;
                    sclk_nxt = 1'b1;
                end
            end
            SPA_H_LOW: begin
                if (div_end) begin
                    st_nxt = SPA_H_HIGH;
                    sclk_nxt = 1'b1;
                end
            end
            SPA_H_HIGH: begin
                sclk_nxt = ~div_end;
                if (div_end) begin
                    rx_nxt = {rx_r[SPA_DATA_W-2:0], miso_s2_r};
                    tx_nxt = {tx_r[SPA_DATA_W-2:0], 1'b0};
                    bit_nxt = bit_r + SPA_BIT_CNT_W'(1);
                    st_nxt = SPA_H_LOW;
                    if (bit_r == SPA_BIT_LAST) begin
                        if (is_data_r) begin
                            done_nxt = 1'b1;
                            rdata_nxt = {rx_r[SPA_DATA_W-2:0], miso_s2_r};
                        end
                        is_data_nxt = 1'b1;
                        tx_nxt = wdata;
                        if (left_r == '0) begin
                            st_nxt = SPA_H_TAIL;
                        end else begin
                            left_nxt = left_r - SPA_LEN_W'(1);
                        end
                    end
                end
            end
            SPA_H_TAIL: begin
                if (div_end) begin
                    cs_n_nxt = 1'b1;
                    busy_nxt = 1'b0;
                    st_nxt = SPA_H_IDLE;
                end
            end
            default: begin
                st_nxt = SPA_H_IDLE;
                cs_n_nxt = 1'b1;
                busy_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        miso_s1_r <= link.miso;
        miso_s2_r <= miso_s1_r;
        if (rst) begin
            st_r <= SPA_H_IDLE;
            div_r <= '0;
            bit_r <= SPA_BIT_FIRST;
            left_r <= '0;
            tx_r <= SPA_BYTE_ZERO;
            rx_r <= SPA_BYTE_ZERO;
            is_data_r <= 1'b0;
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= SPA_BYTE_ZERO;
        end else begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            bit_r <= bit_nxt;
            left_r <= left_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            is_data_r <= is_data_nxt;
            sclk_r <= sclk_nxt;
            cs_n_r <= cs_n_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ==========================================================
    // Link and user outputs
    assign link.sclk = sclk_r;
    assign link.chip_select_n = cs_n_r;
    assign link.mosi = tx_r[SPA_DATA_W-1];
    assign busy = busy_r;
    assign byte_done = done_r;
    assign rdata = rdata_r;
endmodule
`default_nettype wire

// ==== rtl/spa_dev.sv ====
// Device end: SPI slave giving access to registers and the FIFO
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Mode 0: sample on rise, shift on fall
// - Slave only, full-duplex transfer
// - Host sends address then one or more data bytes
// - Read returns addressed register as next byte
// - Host frames single access with chip select
// - Burst increments address after each byte, except at the FIFO address
// - Burst works for writes and reads
// - Host holds select low across burst bytes
// - FIFO address streams all bytes through FIFO
// - FIFO address kept for whole frame
module spa_dev #(
    parameter int DEPTH = 1 << spa_pkg::SPA_ADDR_W
) (
    input wire logic mclk,
    input wire logic rst,
    spa_link_if.dev link,
    input wire logic [spa_pkg::SPA_DATA_W-1:0] fifo_rd_data,
    output logic reg_wr_stb,
    output logic fifo_wr_stb,
    output logic fifo_pop_stb,
    output logic [spa_pkg::SPA_ADDR_W-1:0] wr_addr,
    output logic [spa_pkg::SPA_DATA_W-1:0] wr_data
);
    import spa_pkg::*;

    // ==========================================================
    // Link-domain frame state
    spa_frame_t st_r, st_nxt;
    logic [SPA_BIT_CNT_W-1:0] bit_r, bit_nxt;
    logic [SPA_DATA_W-2:0] shin_r, shin_nxt;
    logic [SPA_ADDR_W-1:0] addr_r, addr_nxt;
    logic wr_r, wr_nxt;
    logic [SPA_DATA_W-1:0] byte_in;
    logic byte_end;
    logic is_fifo;
    logic reg_we;

    // Link-domain event holders
    logic wr_tgl_r, wr_tgl_nxt;
    logic pop_tgl_r, pop_tgl_nxt;
    logic [SPA_ADDR_W-1:0] hold_addr_r, hold_addr_nxt;
    logic [SPA_DATA_W-1:0] hold_data_r, hold_data_nxt;
    logic [SPA_DATA_W-1:0] head_s1_r, head_s2_r;

    // Register storage
    logic [SPA_DATA_W-1:0] regs [DEPTH];

    // Falling-edge shifter
    logic [SPA_DATA_W-1:0] tx_r, tx_nxt;
    logic oe_r;
    logic [SPA_DATA_W-1:0] rd_val;

    // Main-clock side
    logic [SPA_DATA_W-1:0] head_r;
    logic wr_s1_r, wr_s2_r, wr_s3_r;
    logic pop_s1_r, pop_s2_r, pop_s3_r;
    logic reg_stb_r, reg_stb_nxt;
    logic fifo_stb_r, fifo_stb_nxt;
    logic pop_stb_r, pop_stb_nxt;
    logic [SPA_ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
    logic [SPA_DATA_W-1:0] wr_data_r, wr_data_nxt;

    // ==========================================================
    // Rising edge: sample MOSI and decode bytes
    assign byte_in = {shin_r, link.mosi};
    assign byte_end = (bit_r == SPA_BIT_LAST);
    assign is_fifo = (addr_r == SPA_FIFO_ADDR);
    assign reg_we = byte_end && (st_r == SPA_ST_DATA) && wr_r && !is_fifo;

    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r + SPA_BIT_CNT_W'(1);
        shin_nxt = byte_in[SPA_DATA_W-2:0];
        addr_nxt = addr_r;
        wr_nxt = wr_r;
        wr_tgl_nxt = wr_tgl_r;
        pop_tgl_nxt = pop_tgl_r;
        hold_addr_nxt = hold_addr_r;
        hold_data_nxt = hold_data_r;
        if ((bit_r == SPA_BIT_FIRST) && (st_r == SPA_ST_DATA) && !wr_r && is_fifo) begin
            pop_tgl_nxt = ~pop_tgl_r;
        end
        if (byte_end) begin
            if (st_r == SPA_ST_ADDR) begin
                wr_nxt = byte_in[SPA_WR_BIT];
                addr_nxt = byte_in[SPA_ADDR_W-1:0];
                st_nxt = SPA_ST_DATA;
            end else begin
                if (wr_r) begin
                    wr_tgl_nxt = ~wr_tgl_r;
                    hold_addr_nxt = addr_r;
                    hold_data_nxt = byte_in;
                end
                if (!is_fifo) begin
                    addr_nxt = addr_r + SPA_ADDR_STEP;
                end
            end
        end
    end

    // Frame state cleared by chip select, never by the link clock
    always_ff @(posedge link.sclk or posedge link.chip_select_n) begin
        if (link.chip_select_n) begin
            st_r <= SPA_ST_ADDR;
            bit_r <= SPA_BIT_FIRST;
            shin_r <= '0;
            addr_r <= SPA_FIFO_ADDR;
            wr_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            shin_r <= shin_nxt;
            addr_r <= addr_nxt;
            wr_r <= wr_nxt;
        end
    end

    // Event holders persist across frames
    always_ff @(posedge link.sclk or posedge rst) begin
        if (rst) begin
            wr_tgl_r <= 1'b0;
            pop_tgl_r <= 1'b0;
            hold_addr_r <= SPA_FIFO_ADDR;
            hold_data_r <= SPA_BYTE_ZERO;
            head_s1_r <= SPA_BYTE_ZERO;
            head_s2_r <= SPA_BYTE_ZERO;
        end else begin
            wr_tgl_r <= wr_tgl_nxt;
            pop_tgl_r <= pop_tgl_nxt;
            hold_addr_r <= hold_addr_nxt;
            hold_data_r <= hold_data_nxt;
            head_s1_r <= head_r;
            head_s2_r <= head_s1_r;
        end
    end

    always_ff @(posedge link.sclk) begin
        if (reg_we) begin
            regs[addr_r] <= byte_in;
        end
    end

    // ==========================================================
    // Falling edge: drive MISO
    assign rd_val = is_fifo ? head_s2_r : regs[addr_r];

    always_comb begin
        if ((bit_r == SPA_BIT_FIRST) && (st_r == SPA_ST_DATA)) begin
            tx_nxt = rd_val;
        end else begin
            tx_nxt = {tx_r[SPA_DATA_W-2:0], 1'b0};
        end
    end

    always_ff @(negedge link.sclk or posedge link.chip_select_n) begin
        if (link.chip_select_n) begin
            tx_r <= SPA_BYTE_ZERO;
            oe_r <= 1'b0;
        end else begin
            tx_r <= tx_nxt;
            oe_r <= 1'b1;
        end
    end

    assign link.miso = tx_r[SPA_DATA_W-1];
    assign link.miso_oe = oe_r;

    // ==========================================================
    // Main clock: event crossings and user strobes
    always_comb begin
        reg_stb_nxt = 1'b0;
        fifo_stb_nxt = 1'b0;
        pop_stb_nxt = pop_s2_r ^ pop_s3_r;
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        if (wr_s2_r ^ wr_s3_r) begin
            wr_addr_nxt = hold_addr_r;
            wr_data_nxt = hold_data_r;
            reg_stb_nxt = (hold_addr_r != SPA_FIFO_ADDR);
            fifo_stb_nxt = (hold_addr_r == SPA_FIFO_ADDR);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            head_r <= SPA_BYTE_ZERO;
            wr_s1_r <= 1'b0;
            wr_s2_r <= 1'b0;
            wr_s3_r <= 1'b0;
            pop_s1_r <= 1'b0;
            pop_s2_r <= 1'b0;
            pop_s3_r <= 1'b0;
            reg_stb_r <= 1'b0;
            fifo_stb_r <= 1'b0;
            pop_stb_r <= 1'b0;
            wr_addr_r <= SPA_FIFO_ADDR;
            wr_data_r <= SPA_BYTE_ZERO;
        end else begin
            head_r <= fifo_rd_data;
            wr_s1_r <= wr_tgl_r;
            wr_s2_r <= wr_s1_r;
            wr_s3_r <= wr_s2_r;
            pop_s1_r <= pop_tgl_r;
            pop_s2_r <= pop_s1_r;
            pop_s3_r <= pop_s2_r;
            reg_stb_r <= reg_stb_nxt;
            fifo_stb_r <= fifo_stb_nxt;
            pop_stb_r <= pop_stb_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
        end
    end

    assign reg_wr_stb = reg_stb_r;
    assign fifo_wr_stb = fifo_stb_r;
    assign fifo_pop_stb = pop_stb_r;
    assign wr_addr = wr_addr_r;
    assign wr_data = wr_data_r;
endmodule
`default_nettype wire

// ==== tb/spa_link_chk.sv ====
// Checker for the serial link between host and device
`timescale 1ns/10ps
`default_nettype none
module spa_link_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    logic [2:0] rise_cnt_r;
    // ==========================================================
    // Rising clock edges within the current byte
    always_ff @(posedge mclk) begin
        if (rst || chip_select_n) begin
            rise_cnt_r <= 3'h0;
        end else if ($rose(sclk)) begin
            rise_cnt_r <= rise_cnt_r + 3'h1;
        end
    end
    // ==========================================================
    // Link properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence lead_seq;
        !sclk [*4] ##1 sclk;
    endsequence
    sequence high_seq;
        sclk [*4] ##1 !sclk;
    endsequence
    a_sclk_idle_low: assert property (chip_select_n |-> !sclk)
        else $error("serial clock not low outside frame");
    a_sclk_high_span: assert property ($rose(sclk) |-> high_seq)
        else $error("serial clock high phase wrong");
    a_mosi_on_fall: assert property (!chip_select_n && $past(!chip_select_n) && $changed(mosi) |-> $fell(sclk))
        else $error("mosi changed away from falling edge");
    a_miso_on_fall: assert property (!chip_select_n && $changed(miso) |-> $fell(sclk))
        else $error("miso changed away from falling edge");
    a_oe_idle_off: assert property (chip_select_n |-> !miso_oe)
        else $error("miso driven outside frame");
    a_oe_first_fall: assert property ($rose(miso_oe) |-> $fell(sclk) && !chip_select_n)
        else $error("miso enable rose off a falling edge");
    a_cs_lead_gap: assert property ($fell(chip_select_n) |-> lead_seq)
        else $error("select to first clock spacing wrong");
    a_cs_tail_gap: assert property ($rose(chip_select_n) |-> $past(!sclk, 1) && $past(!sclk, 3))
        else $error("select raised too soon after clock");
    a_whole_bytes: assert property ($rose(chip_select_n) |-> rise_cnt_r == 3'h0)
        else $error("frame ended within a byte");
endmodule
`default_nettype wire

// ==== tb/test_spi_register_access_slave.sv ====
// Self-checking bench for the SPI register access link
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_spi_register_access_slave;
    import spa_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b0;
    logic req = 1'b0;
    logic req_write = 1'b0;
    logic [SPA_ADDR_W-1:0] req_addr = 7'h00;
    logic [SPA_LEN_W-1:0] req_len = 8'h00;
    logic [SPA_DATA_W-1:0] wdata = 8'h00;
    logic [SPA_DATA_W-1:0] fifo_rd_data = 8'h00;
    logic busy, byte_done, reg_wr_stb, fifo_wr_stb, fifo_pop_stb;
    logic reg_wr_stb_2, fifo_wr_stb_2, fifo_pop_stb_2;
    logic [SPA_DATA_W-1:0] rdata, wr_data, wr_data_2, got;
    logic [SPA_ADDR_W-1:0] wr_addr, wr_addr_2;
    logic [SPA_DATA_W-1:0] reg_m [128];
    logic [14:0] wr_q [$];
    logic [7:0] fw_q [$];
    logic [7:0] fifo_q [$];
    int comparisons = 0;
    int fail_count = 0;
    int wr2_count = 0;
    integer seed = 63580;
    spa_link_if link1 ();
    spa_link_if link2 ();
    spa_host u_spa_host (.mclk(mclk), .rst(rst), .link(link1), .req(req), .req_write(req_write),
        .req_addr(req_addr), .req_len(req_len), .wdata(wdata), .busy(busy), .byte_done(byte_done), .rdata(rdata));
    spa_dev u_spa_dev (.mclk(mclk), .rst(rst), .link(link1), .fifo_rd_data(fifo_rd_data), .reg_wr_stb(reg_wr_stb),
        .fifo_wr_stb(fifo_wr_stb), .fifo_pop_stb(fifo_pop_stb), .wr_addr(wr_addr), .wr_data(wr_data));
    spa_dev u_spa_dev_abort (.mclk(mclk), .rst(rst), .link(link2), .fifo_rd_data(8'h00),
        .reg_wr_stb(reg_wr_stb_2), .fifo_wr_stb(fifo_wr_stb_2), .fifo_pop_stb(fifo_pop_stb_2),
        .wr_addr(wr_addr_2), .wr_data(wr_data_2));
    spa_link_chk u_spa_link_chk (.mclk(mclk), .rst(rst), .sclk(link1.sclk), .chip_select_n(link1.chip_select_n),
        .mosi(link1.mosi), .miso(link1.miso), .miso_oe(link1.miso_oe));
    always #10 mclk = ~mclk;
    initial begin
        link2.sclk = 1'b0;
        link2.chip_select_n = 1'b1;
        link2.mosi = 1'b0;
    end
    // ==========================================================
    // Device user side monitors
    always @(negedge mclk) begin
        logic [14:0] e;
        logic [7:0] f;
        if (reg_wr_stb === 1'b1) begin
            e = wr_q.pop_front();
            `CHECK({wr_addr, wr_data}, e)
        end
        if (fifo_wr_stb === 1'b1) begin
            f = fw_q.pop_front();
            `CHECK(wr_data, f)
        end
        if (reg_wr_stb_2 === 1'b1) begin
            wr2_count++;
            `CHECK({wr_addr_2, wr_data_2}, {7'h05, 8'h3C})
        end
    end
    always @(negedge mclk) begin
        if (fifo_pop_stb === 1'b1) begin
            void'(fifo_q.pop_front());
            fifo_rd_data = (fifo_q.size() > 0) ? fifo_q[0] : 8'h5A;
        end
    end
    // ==========================================================
    // Host frame with model of the register file and FIFO
    task automatic frame(input logic wr, input logic [6:0] addr, input int n);
        logic [6:0] a;
        logic [7:0] d;
        logic [7:0] nd;
        logic [7:0] snap [$];
        int k;
        int t;
        a = addr;
        k = 0;
        snap = fifo_q;
        d = 8'($random(seed));
        @(negedge mclk);
        req = 1'b1;
        req_write = wr;
        req_addr = addr;
        req_len = SPA_LEN_W'(n);
        wdata = d;
        @(negedge mclk);
        req = 1'b0;
        // Host takes each data byte as the byte before it ends
        repeat (8) @(posedge link1.sclk);
        @(negedge link1.sclk);
        @(negedge mclk);
        nd = 8'($random(seed));
        wdata = nd;
        for (int i = 0; i < n; i++) begin
            if (wr && a == SPA_FIFO_ADDR) fw_q.push_back(d);
            else if (wr) begin
                wr_q.push_back({a, d});
                reg_m[a] = d;
            end
            t = 0;
            while (byte_done !== 1'b1 && t < 3000) begin
                @(negedge mclk);
                t++;
            end
            `CHECK(byte_done, 1'b1)
            if (!wr && a == SPA_FIFO_ADDR) begin
                `CHECK(rdata, snap[k])
                k++;
            end else if (!wr) `CHECK(rdata, reg_m[a])
            d = nd;
            nd = 8'($random(seed));
            wdata = nd;
            a = (a == SPA_FIFO_ADDR) ? a : a + SPA_ADDR_STEP;
            @(negedge mclk);
        end
        t = 0;
        while (busy !== 1'b0 && t < 100) begin
            @(negedge mclk);
            t++;
        end
        `CHECK(busy, 1'b0)
        repeat (6) @(negedge mclk);
    endtask
    // ==========================================================
    // Bench driven serial bits on the second link
    task automatic raw(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            link2.mosi = b[7-i];
            #40 link2.sclk = 1'b1;
            got = {got[6:0], link2.miso};
            #40 link2.sclk = 1'b0;
        end
    endtask
    task automatic stop_test();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        fail_count++;
        stop_test();
    end
    // ==========================================================
    // Scenarios
    initial begin
        #1 rst = 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        frame(1'b1, 7'h01, 127);
        frame(1'b0, 7'h01, 127);
        for (int j = 0; j < 6; j++) begin
            req_addr = 7'(32'h1 + ($random(seed) & 32'h7D));
            frame(1'b1, req_addr, 1);
            frame(1'b0, req_addr, 1);
        end
        frame(1'b1, SPA_FIFO_ADDR, 4);
        for (int j = 0; j < 9; j++) fifo_q.push_back(8'($random(seed)));
        fifo_rd_data = fifo_q[0];
        repeat (40) @(negedge mclk);
        frame(1'b0, SPA_FIFO_ADDR, 5);
        frame(1'b0, 7'h7E, 4);
        `CHECK(fifo_q.size(), 2)
        #7 link2.chip_select_n = 1'b0;
        #40 raw(8'hFF, 5);
        #40 link2.chip_select_n = 1'b1;
        #200 link2.chip_select_n = 1'b0;
        #40 raw({1'b1, 7'h05}, 8);
        raw(8'h3C, 8);
        #40 link2.chip_select_n = 1'b1;
        link2.mosi = 1'b1;
        #400 link2.chip_select_n = 1'b0;
        #40 raw({1'b0, 7'h05}, 8);
        raw(8'h00, 8);
        `CHECK(got, 8'h3C)
        #40 link2.chip_select_n = 1'b1;
        repeat (20) @(negedge mclk);
        `CHECK(wr2_count, 1)
        `CHECK(wr_q.size() + fw_q.size(), 0)
        stop_test();
    end
endmodule
`default_nettype wire
